// ==== hdl/cocl_ctrl_low.sv ====
// Low option control register of the charge controller and its decoded controls
`default_nettype none
`include "cocl_map.svh"
// Notes on behaviour
// - 8-bit read/write register at offset zero, reset value 0x0E.
// - Latch enabled and profile comparator on: event flag sticks until host clears.
// - Toggling the latch enable bit releases the latched comparator pin.
// - Bit 6 set turns system undervoltage protection off.
// - Bit 5 enables learn mode, reset zero.
// - Bit 4 picks input monitor gain: 0 is 20x, 1 is 40x.
// - Bit 3 picks battery monitor gain: 0 is 8x, 1 is 64x; reset 1.
// - Bit 2 set: linear precharge while battery below minimum system voltage; reset 1.
// - Bit 2 clear: switch full on when charging, 5V floor; else off, battery+160mV.
// - Bit 2 set: precharge current is lower of two settings; system at minimum.
// - Host sets bit 1 to enable input limit loop; charger disabling clears it.
// - In on-the-go mode bit 1 gates output current regulation instead of the input limit loop.
// - Bit 0 clear with valid settings starts charging; bit 0 set inhibits.
// - Auto-off option with battery absent clears bit 1; host may set again.
module cocl_ctrl_low #(
    parameter int CURRENT_W = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Register port from the serial host bus engine
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_read_in,
    output logic [7:0] reg_rdata_out,
    // Charger state, same clock
    input wire logic input_limit_auto_off_in,
    input wire logic charger_loop_disable_in,
    input wire logic otg_mode_in,
    input wire logic charge_settings_valid_in,
    input wire logic battery_below_min_in,
    input wire logic battery_below_floor_in,
    input wire logic [CURRENT_W-1:0] charge_current_setting_in,
    input wire logic [CURRENT_W-1:0] precharge_current_setting_in,
    input wire logic comparator_trip_in,
    input wire logic profile_comparator_enable_in,
    input wire logic comparator_status_clear_in,
    // Pin from outside the clock domain
    input wire logic battery_present_pin_in,
    // Decoded controls
    output logic comparator_latch_enable_out,
    output logic comparator_event_flag_out,
    output logic comparator_output_pin_n_out,
    output logic system_undervoltage_protect_out,
    output logic battery_discharge_learn_enable_out,
    output logic [7:0] input_monitor_gain_out,
    output logic [7:0] battery_monitor_gain_out,
    output cocl_pkg::cocl_switch_t battery_switch_out,
    output cocl_pkg::cocl_sys_sel_t system_target_sel_out,
    output logic [15:0] system_offset_mv_out,
    output logic [CURRENT_W-1:0] precharge_current_out,
    output logic input_limit_loop_enable_out,
    output logic otg_output_current_loop_out,
    output logic charge_start_out
);
    import cocl_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] ctrl;
        logic pres_s1;
        logic pres_s2;
        logic [7:0] rdata;
        cocl_switch_t sw;
        cocl_sys_sel_t sys;
        logic [15:0] sys_mv;
        logic [CURRENT_W-1:0] pre_i;
        logic [7:0] in_gain;
        logic [7:0] bat_gain;
        logic chg;
    } cocl_ctrl_state_t;

    cocl_ctrl_state_t state_r;
    cocl_ctrl_state_t state_nxt;

    // Bit test helper used by several decodes
    function automatic logic ctrl_bit(input logic [7:0] v, input int idx);
        return v[idx];
    endfunction

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic hit;
        logic ldo;
        hit = 1'b0;
        ldo = 1'b0;
        state_nxt = state_r;
        // Battery present pin through two flops before use
        state_nxt.pres_s1 = battery_present_pin_in;
        state_nxt.pres_s2 = state_r.pres_s1;
        hit = reg_addr_in == `COCL_OFFSET_CTRL_LOW;
        // Host write stores all bits
        if (reg_write_in && hit) begin
            state_nxt.ctrl = reg_wdata_in;
        end
        // Device clear of the loop bit wins over a host write in the same cycle
        if (charger_loop_disable_in ||
            (input_limit_auto_off_in && !state_r.pres_s2)) begin
            state_nxt.ctrl[`COCL_BIT_IIN_LOOP] = 1'b0;
        end
        // Read data captured on a read strobe; other offsets read zero
        if (reg_read_in) begin
            state_nxt.rdata = hit ? state_r.ctrl : 8'h00;
        end
        // Gains from the stored bits
        state_nxt.in_gain = ctrl_bit(state_r.ctrl, `COCL_BIT_IN_GAIN) ?
            `COCL_IN_GAIN_HI : `COCL_IN_GAIN_LO;
        state_nxt.bat_gain = ctrl_bit(state_r.ctrl, `COCL_BIT_BAT_GAIN) ?
            `COCL_BAT_GAIN_HI : `COCL_BAT_GAIN_LO;
        // Charge start held off by the inhibit bit
        state_nxt.chg = !ctrl_bit(state_r.ctrl, `COCL_BIT_HOLD_OFF) &&
            charge_settings_valid_in;
        // Battery switch and system target
        ldo = ctrl_bit(state_r.ctrl, `COCL_BIT_LDO);
        state_nxt.sys_mv = 16'h0000;
        state_nxt.pre_i = charge_current_setting_in;
        if (ldo) begin
            state_nxt.sys = COCL_SYS_MIN;
            state_nxt.sw = battery_below_min_in ? COCL_SW_LINEAR : COCL_SW_FULL;
            if (precharge_current_setting_in < charge_current_setting_in) begin
                state_nxt.pre_i = precharge_current_setting_in;
            end
            if (!state_nxt.chg) begin
                state_nxt.sw = COCL_SW_OFF;
            end
        end else if (state_nxt.chg) begin
            state_nxt.sw = COCL_SW_FULL;
            state_nxt.sys = battery_below_floor_in ? COCL_SYS_FLOOR : COCL_SYS_BAT_PLUS;
            state_nxt.sys_mv = battery_below_floor_in ? `COCL_SYS_FLOOR_MV : 16'h0000;
        end else begin
            state_nxt.sw = COCL_SW_OFF;
            state_nxt.sys = COCL_SYS_BAT_PLUS;
            state_nxt.sys_mv = `COCL_SYS_HEADROOM_MV;
        end
    end

    // Register the state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= '0;
            state_r.ctrl <= `COCL_RESET_CTRL_LOW;
            state_r.pres_s1 <= 1'b1;
            state_r.pres_s2 <= 1'b1;
            state_r.sw <= COCL_SW_OFF;
            state_r.sys <= COCL_SYS_BAT_PLUS;
            state_r.in_gain <= `COCL_IN_GAIN_LO;
            state_r.bat_gain <= `COCL_BAT_GAIN_HI;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ****************************************
    // Comparator latch
    // ****************************************
    cocl_cmp_latch u_cmp (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .latch_enable_in(state_r.ctrl[`COCL_BIT_CMP_LATCH]),
        .profile_comparator_enable_in(profile_comparator_enable_in),
        .trip_in(comparator_trip_in),
        .status_clear_in(comparator_status_clear_in),
        .event_flag_out(comparator_event_flag_out),
        .comparator_output_pin_n_out(comparator_output_pin_n_out)
    );

    // Outputs straight from the stored state; the two loop enables are also gated by otg_mode_in
    assign reg_rdata_out = state_r.rdata;
    assign comparator_latch_enable_out = state_r.ctrl[`COCL_BIT_CMP_LATCH];
    assign system_undervoltage_protect_out = !state_r.ctrl[`COCL_BIT_UVP_DISABLE];
    assign battery_discharge_learn_enable_out = state_r.ctrl[`COCL_BIT_LEARN];
    assign input_monitor_gain_out = state_r.in_gain;
    assign battery_monitor_gain_out = state_r.bat_gain;
    assign battery_switch_out = state_r.sw;
    assign system_target_sel_out = state_r.sys;
    assign system_offset_mv_out = state_r.sys_mv;
    assign precharge_current_out = state_r.pre_i;
    assign input_limit_loop_enable_out = state_r.ctrl[`COCL_BIT_IIN_LOOP] && !otg_mode_in;
    assign otg_output_current_loop_out = state_r.ctrl[`COCL_BIT_IIN_LOOP] &&
        otg_mode_in;
    assign charge_start_out = state_r.chg;
endmodule // cocl_ctrl_low
`default_nettype wire

// ==== pkg/cocl_map.svh ====
// Register offset, field positions, reset value and fixed levels of the low option register
`ifndef COCL_MAP_SVH
`define COCL_MAP_SVH

`define COCL_OFFSET_CTRL_LOW 8'h00
`define COCL_RESET_CTRL_LOW 8'h0E
`define COCL_BIT_CMP_LATCH 7
`define COCL_BIT_UVP_DISABLE 6
`define COCL_BIT_LEARN 5
`define COCL_BIT_IN_GAIN 4
`define COCL_BIT_BAT_GAIN 3
`define COCL_BIT_LDO 2
`define COCL_BIT_IIN_LOOP 1
`define COCL_BIT_HOLD_OFF 0
`define COCL_IN_GAIN_LO 8'h14
`define COCL_IN_GAIN_HI 8'h28
`define COCL_BAT_GAIN_LO 8'h08
`define COCL_BAT_GAIN_HI 8'h40
`define COCL_SYS_FLOOR_MV 16'h1388
`define COCL_SYS_HEADROOM_MV 16'h00A0

`endif

// ==== pkg/cocl_pkg.sv ====
// Types shared by the low option register block
`default_nettype none
package cocl_pkg;
    // Battery switch drive
    typedef enum logic [1:0] {COCL_SW_OFF, COCL_SW_LINEAR, COCL_SW_FULL} cocl_switch_t;
    // Source of the system voltage target
    typedef enum logic [1:0] {COCL_SYS_MIN, COCL_SYS_FLOOR, COCL_SYS_BAT_PLUS} cocl_sys_sel_t;
    // Comparator latch state
    typedef enum logic {COCL_CMP_IDLE, COCL_CMP_HELD} cocl_cmp_st_t;
endpackage : cocl_pkg
`default_nettype wire

// ==== hdl/cocl_cmp_latch.sv ====
// Latching of the independent comparator event flag and output pin
`default_nettype none
module cocl_cmp_latch (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Controls
    input wire logic latch_enable_in,
    input wire logic profile_comparator_enable_in,
    input wire logic trip_in,
    input wire logic status_clear_in,
    // Results
    output logic event_flag_out,
    output logic comparator_output_pin_n_out
);
    import cocl_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        cocl_cmp_st_t st;
        logic flag;
        logic pin_n;
        logic latch_d;
    } cocl_cmp_state_t;

    cocl_cmp_state_t state_r;
    cocl_cmp_state_t state_nxt;

    // Next state: latch holds across trip release, toggle releases the pin
    always_comb begin
        logic toggled;
        toggled = 1'b0;
        state_nxt = state_r;
        state_nxt.latch_d = latch_enable_in;
        toggled = latch_enable_in != state_r.latch_d;
        unique case (state_r.st)
            COCL_CMP_IDLE: begin
                state_nxt.pin_n = ~trip_in;
                if (trip_in && latch_enable_in) begin
                    state_nxt.st = COCL_CMP_HELD;
                end
            end
            COCL_CMP_HELD: begin
                state_nxt.pin_n = 1'b0;
                if (toggled) begin
                    state_nxt.st = COCL_CMP_IDLE;
                    state_nxt.pin_n = 1'b1;
                end
            end
        endcase
        // Flag: set beats clear; sticky only when latched in the profile
        if (trip_in && profile_comparator_enable_in) begin
            state_nxt.flag = 1'b1;
        end else if (!latch_enable_in || status_clear_in) begin
            state_nxt.flag = 1'b0;
        end
    end

    // Register the state
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= '{st: COCL_CMP_IDLE, flag: 1'b0, pin_n: 1'b1, latch_d: 1'b0};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign event_flag_out = state_r.flag;
    assign comparator_output_pin_n_out = state_r.pin_n;
endmodule // cocl_cmp_latch
`default_nettype wire

// ==== testbench/cocl_ctrl_low_checker.sv ====
// Assertion checker for the low option register block
`default_nettype none
module cocl_ctrl_low_checker (
    // Watched ports
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_write_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_read_in,
    input wire logic [7:0] reg_rdata_out,
    input wire logic charger_loop_disable_in,
    input wire logic comparator_trip_in,
    input wire logic profile_comparator_enable_in,
    input wire logic comparator_latch_enable_out,
    input wire logic comparator_event_flag_out,
    input wire logic system_undervoltage_protect_out,
    input wire logic [7:0] input_monitor_gain_out,
    input wire logic [7:0] battery_monitor_gain_out,
    input wire logic input_limit_loop_enable_out,
    input wire logic charge_start_out
);
    // ****************
    // Properties
    // ****************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // Host write to the mapped offset
    sequence s_wr;
        reg_write_in && reg_addr_in == 8'h00;
    endsequence
    a_latch_bit: assert property (s_wr |=>
        comparator_latch_enable_out == $past(reg_wdata_in[7])) else $error("latch bit");
    a_uvp_inverted: assert property (s_wr |=>
        system_undervoltage_protect_out != $past(reg_wdata_in[6])) else $error("uvp");
    a_in_gain: assert property (s_wr |=> ##1
        input_monitor_gain_out == ($past(reg_wdata_in[4], 2) ? 8'h28 : 8'h14))
        else $error("in gain");
    a_bat_gain: assert property (s_wr |=> ##1
        battery_monitor_gain_out == ($past(reg_wdata_in[3], 2) ? 8'h40 : 8'h08))
        else $error("bat gain");
    a_hold_off: assert property (s_wr ##0 reg_wdata_in[0] |=> ##1
        !charge_start_out) else $error("charge not held");
    a_loop_cleared: assert property (charger_loop_disable_in |=>
        !input_limit_loop_enable_out) else $error("loop kept");
    a_flag_sets: assert property (comparator_trip_in &&
        profile_comparator_enable_in |=> comparator_event_flag_out) else $error("flag");
    a_unmapped_zero: assert property (reg_read_in && reg_addr_in != 8'h00 |=>
        reg_rdata_out == 8'h00) else $error("unmapped read");
endmodule // cocl_ctrl_low_checker
bind cocl_ctrl_low cocl_ctrl_low_checker u_chk (.clk_in, .rst_n_in, .reg_addr_in, .reg_write_in,
    .reg_wdata_in, .reg_read_in, .reg_rdata_out, .charger_loop_disable_in, .comparator_trip_in,
    .profile_comparator_enable_in, .comparator_latch_enable_out, .comparator_event_flag_out,
    .system_undervoltage_protect_out, .input_monitor_gain_out, .battery_monitor_gain_out,
    .input_limit_loop_enable_out, .charge_start_out);
`default_nettype wire

// ==== testbench/cocl_host_model.sv ====
// Host controller model driving the register port
`default_nettype none
module cocl_host_model (
    // Clock
    input wire logic clk_in,
    // Register port
    output logic [7:0] reg_addr_out,
    output logic reg_write_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_read_out,
    input wire logic [7:0] reg_rdata_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle bus
    initial begin
        {reg_addr_out, reg_wdata_out, reg_write_out, reg_read_out} = '0;
    end
    // Single byte write; released lines show the inverse of the last value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in) #1;
        {reg_addr_out, reg_wdata_out, reg_write_out} = {a, d, 1'b1};
        @(posedge clk_in) #1;
        {reg_addr_out, reg_wdata_out, reg_write_out} = {~a, ~d, 1'b0};
    endtask
    // Single byte read; data taken the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_in) #1;
        {reg_addr_out, reg_read_out} = {a, 1'b1};
        @(posedge clk_in) #1;
        {reg_addr_out, reg_read_out} = {~a, 1'b0};
        d = reg_rdata_in;
    endtask
endmodule // cocl_host_model
`default_nettype wire

// ==== testbench/cocl_ctrl_low_tb_top.sv ====
// Self-checking testbench of the low option register block
`default_nettype none
module cocl_ctrl_low_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import cocl_pkg::*;
    // ****************
    // Signals
    // ****************
    logic clk_in = 1'b0, rst_n_in = 1'b0, auto_off = 1'b0, loop_dis = 1'b0, otg = 1'b0;
    logic below_min = 1'b0, below_floor = 1'b0, trip = 1'b0, prof = 1'b0, st_clr = 1'b0;
    logic bat_pres = 1'b1, wr_s, rd_s, latch, flag, pin_n, uvp, learn, in_loop, otg_loop, start;
    logic [7:0] addr, wdata, rdata, rv, in_gain, bat_gain;
    logic [15:0] offs, pre_out;
    logic valid = 1'b1;
    logic [15:0] chg_set = 16'h0064, pre_set = 16'h0028;
    cocl_switch_t sw;
    cocl_sys_sel_t sel;
    logic [7:0] pats [4] = '{8'hF1, 8'h5A, 8'hA5, 8'h0E};
    int err_total = 0;
    int compares = 0;
    // Clock
    always #5 clk_in = ~clk_in;
    // Host and design
    cocl_host_model host (.clk_in(clk_in), .reg_addr_out(addr), .reg_write_out(wr_s),
        .reg_wdata_out(wdata), .reg_read_out(rd_s), .reg_rdata_in(rdata));
    cocl_ctrl_low dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .reg_addr_in(addr),
        .reg_write_in(wr_s), .reg_wdata_in(wdata), .reg_read_in(rd_s), .reg_rdata_out(rdata),
        .input_limit_auto_off_in(auto_off), .charger_loop_disable_in(loop_dis),
        .otg_mode_in(otg), .charge_settings_valid_in(valid), .battery_below_min_in(below_min),
        .battery_below_floor_in(below_floor), .charge_current_setting_in(chg_set),
        .precharge_current_setting_in(pre_set), .comparator_trip_in(trip),
        .profile_comparator_enable_in(prof), .comparator_status_clear_in(st_clr),
        .battery_present_pin_in(bat_pres), .comparator_latch_enable_out(latch),
        .comparator_event_flag_out(flag), .comparator_output_pin_n_out(pin_n),
        .system_undervoltage_protect_out(uvp), .battery_discharge_learn_enable_out(learn),
        .input_monitor_gain_out(in_gain), .battery_monitor_gain_out(bat_gain),
        .battery_switch_out(sw), .system_target_sel_out(sel), .system_offset_mv_out(offs),
        .precharge_current_out(pre_out), .input_limit_loop_enable_out(in_loop),
        .otg_output_current_loop_out(otg_loop), .charge_start_out(start));
    // Compare and count
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Write, check decoded controls, read back
    task automatic wchk(input logic [7:0] d);
        host.wr(8'h00, d);
        @(posedge clk_in) #1;
        chk("latch", latch, d[7]);
        chk("uvp", uvp, !d[6]);
        chk("learn", learn, d[5]);
        chk("in_gain", in_gain, d[4] ? 8'h28 : 8'h14);
        chk("bat_gain", bat_gain, d[3] ? 8'h40 : 8'h08);
        chk("start", start, !d[0]);
        host.rd(8'h00, rv);
        chk("readback", rv, d);
    endtask
    // ****************
    // Tests
    // ****************
    initial begin
        repeat (5) @(posedge clk_in);
        #1 rst_n_in = 1'b1;
        host.rd(8'h00, rv);
        chk("reset", rv, 8'h0E);
        chk("learn_rst", learn, 1'b0);
        foreach (pats[i]) wchk(pats[i]);
        host.wr(8'h01, 8'hFF);
        host.rd(8'h01, rv);
        chk("unmapped", rv, 8'h00);
        host.rd(8'h00, rv);
        chk("kept", rv, 8'h0E);
        $display("test register map done");
        loop_dis = 1'b1;
        @(posedge clk_in) #1 loop_dis = 1'b0;
        host.rd(8'h00, rv);
        chk("loop_clr", rv, 8'h0C);
        wchk(8'h02);
        chk("in_loop_on", in_loop, 1'b1);
        chk("otg_off", otg_loop, 1'b0);
        otg = 1'b1;
        @(posedge clk_in) #1 chk("otg_loop", otg_loop, 1'b1);
        chk("in_loop", in_loop, 1'b0);
        {otg, auto_off, bat_pres} = 3'b010;
        repeat (4) @(posedge clk_in);
        host.rd(8'h00, rv);
        chk("auto_off", rv, 8'h00);
        bat_pres = 1'b1;
        repeat (3) @(posedge clk_in);
        wchk(8'h02);
        $display("test input loop done");
        prof = 1'b1;
        wchk(8'h80);
        trip = 1'b1;
        @(posedge clk_in) #1 trip = 1'b0;
        repeat (2) @(posedge clk_in);
        #1 chk("flag", flag, 1'b1);
        chk("pin_held", pin_n, 1'b0);
        st_clr = 1'b1;
        @(posedge clk_in) #1 st_clr = 1'b0;
        @(posedge clk_in) #1 chk("flag_clr", flag, 1'b0);
        host.wr(8'h00, 8'h00);
        host.wr(8'h00, 8'h80);
        @(posedge clk_in) #1 chk("pin_free", pin_n, 1'b1);
        $display("test comparator done");
        below_min = 1'b1;
        wchk(8'h04);
        chk("sw_lin", sw, COCL_SW_LINEAR);
        chk("pre_cur", pre_out, 16'h0028);
        chk("sys_min", sel, COCL_SYS_MIN);
        below_floor = 1'b1;
        wchk(8'h00);
        chk("sw_full", sw, COCL_SW_FULL);
        chk("floor", offs, 16'h1388);
        chk("sel_floor", sel, COCL_SYS_FLOOR);
        wchk(8'h01);
        chk("sw_off", sw, COCL_SW_OFF);
        chk("bat_plus", offs, 16'h00A0);
        chk("sel_bat", sel, COCL_SYS_BAT_PLUS);
        wchk(8'h00);
        valid = 1'b0;
        @(posedge clk_in) #1 chk("no_valid", start, 1'b0);
        valid = 1'b1;
        {below_min, pre_set} = {1'b0, 16'h0080};
        wchk(8'h04);
        chk("sw_ldo_full", sw, COCL_SW_FULL);
        chk("pre_cap", pre_out, 16'h0064);
        $display("test precharge done");
        rst_n_in = 1'b0;
        @(posedge clk_in) #1 rst_n_in = 1'b1;
        host.rd(8'h00, rv);
        chk("rst_mid", rv, 8'h0E);
        chk("in_gain_rst", in_gain, 8'h14);
        chk("bat_gain_rst", bat_gain, 8'h40);
        $display("test reset done");
        print_verdict();
    end
    // Watchdog
    initial begin
        #20000;
        err_total++;
        print_verdict();
    end
endmodule // cocl_ctrl_low_tb_top
`default_nettype wire
